// File: core/measurement_sequencer_limit_monitor.sv
// Measurement sequencer with limit checking for a sensor and 8-input converter.
// Assumes the analog front end converts while conv_active_o is high and presents
// its code on adc_code_i; the serial protocol engine drives the register port.
`timescale 1ns/1ps
`default_nettype none

module measurement_sequencer_limit_monitor
    import monseq_pkg::*;
#(
    parameter int INT_CYCLES  = monseq_pkg::INT_TEMP_CYCLES,
    parameter int EXT_CYCLES  = monseq_pkg::EXT_TEMP_CYCLES,
    parameter int AIN_CYCLES  = monseq_pkg::VOLT_CYCLES,
    parameter int NCH         = monseq_pkg::NUM_CHANNELS
) (
    // clock, reset, enable
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // register port from the serial engine
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic                 serial_active_i,
    output logic [7:0]                reg_rdata_o,
    // configuration levels
    input  wire logic                 monitor_enable_i,
    input  wire logic                 ext_sensor_enable_i,
    input  wire logic                 int_active_high_i,
    input  wire logic [NCH-1:0]       mask_i,
    input  wire logic [NCH*8-1:0]     upper_limit_i,
    input  wire logic [NCH*8-1:0]     lower_limit_i,
    // analog front end
    input  wire logic [9:0]           adc_code_i,
    output logic                      conv_active_o,
    output logic [3:0]                conv_channel_o,
    output logic                      conv_use_int_ref_o,
    output logic                      adc_reset_o,
    // interrupt pin
    output logic                      int_o
);

    import monseq_pkg::*;

    typedef enum logic {ST_IDLE, ST_CONVERT} seq_state_type;

    seq_state_type    state_r;
    logic [7:0]       ctrl2_r;
    logic [3:0]       chan_r;
    logic [3:0]       chan_nxt;
    logic [15:0]      timer_r;
    logic [15:0]      timer_last;
    logic             sample_valid;
    logic             avg_clear;
    logic             avg_done;
    logic [9:0]       avg_result;
    logic [NCH-1:0]   flags_r;
    logic [NCH-1:0]   flag_set;
    logic [NCH-1:0]   flag_clr;
    logic             violation;
    logic [7:0]       cur_upper;
    logic [7:0]       cur_lower;
    logic             is_temp;
    logic [7:0]       status1;
    logic [7:0]       status2;
    logic [9:0]       result_mem [NCH];
    logic             single_mode;
    logic [3:0]       sel_chan;
    logic             run;

    // mode fields of the channel mode register
    assign single_mode = ctrl2_r[CTRL2_SINGLE_BIT];
    assign sel_chan    = ctrl2_r[CTRL2_SEL_LSB +: 4];

    assign run = monitor_enable_i;

    always_comb begin
        chan_nxt = CH_SUPPLY;
        if (single_mode) begin
            // select zero supply; out-of-range selects fall back to supply
            chan_nxt = (sel_chan > CH_LAST) ? CH_SUPPLY : sel_chan;
        end else begin
            case (chan_r)
                CH_SUPPLY:   chan_nxt = CH_INT_TEMP;
                CH_INT_TEMP: chan_nxt = ext_sensor_enable_i ? CH_EXT_TEMP : CH_AIN1;
                CH_EXT_TEMP: chan_nxt = CH_AIN3;
                CH_LAST:     chan_nxt = CH_SUPPLY;
                default:     chan_nxt = chan_r + 4'h1;
            endcase
        end
    end

    always_comb begin
        case (chan_r)
            CH_INT_TEMP: timer_last = 16'(INT_CYCLES - 1);
            CH_EXT_TEMP: timer_last = 16'(EXT_CYCLES - 1);
            default:     timer_last = 16'(AIN_CYCLES - 1);
        endcase
    end

    assign sample_valid = (state_r == ST_CONVERT) && !serial_active_i
                          && (timer_r == timer_last);
    // abort clears the partial average as well
    assign avg_clear    = serial_active_i || (state_r == ST_IDLE);

    // sequencing state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            chan_r  <= CH_SUPPLY;
        end else if (ce_i) begin
            case (state_r)
                ST_IDLE: begin
                    if (run && !serial_active_i) begin
                        state_r <= ST_CONVERT;
                        chan_r  <= single_mode ? chan_nxt : CH_SUPPLY;
                    end
                end
                ST_CONVERT: begin
                    if (!run) begin
                        state_r <= ST_IDLE;
                    end else if (avg_done) begin
                        chan_r <= chan_nxt;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // per-reading timer
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            timer_r <= '0;
        end else if (ce_i) begin
            // abort and hold while the host talks
            if (serial_active_i || state_r != ST_CONVERT || avg_done) begin
                timer_r <= '0;
            end else if (timer_r == timer_last) begin
                timer_r <= '0;
            end else begin
                timer_r <= timer_r + 16'h0001;
            end
        end
    end

    reading_averager #(
        .CODE_W (CODE_BITS),
        .COUNT  (AVG_COUNT)
    ) u_avg (
        .mclk_i         (mclk_i),
        .rst_i          (rst_i),
        .ce_i           (ce_i),
        .clear_i        (avg_clear),
        .avg_enable_i   (!ctrl2_r[CTRL2_AVG_OFF]),
        .sample_valid_i (sample_valid),
        .sample_i       (adc_code_i),
        .done_o         (avg_done),
        .result_o       (avg_result)
    );

    assign is_temp   = (chan_r == CH_INT_TEMP) || (chan_r == CH_EXT_TEMP);
    assign cur_upper = upper_limit_i[chan_r*8 +: 8];
    assign cur_lower = lower_limit_i[chan_r*8 +: 8];

    // window check on the upper bits
    limit_compare #(
        .CODE_W  (CODE_BITS),
        .LIMIT_W (LIMIT_BITS)
    ) u_cmp (
        .code_i      (avg_result),
        .upper_i     (cur_upper),
        .lower_i     (cur_lower),
        .signed_i    (is_temp),
        .violation_o (violation)
    );

    // result storage, one 10-bit word per channel
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NCH; i++) begin
                result_mem[i] <= '0;
            end
        end else if (ce_i && avg_done) begin
            result_mem[chan_r] <= avg_result;
        end
    end

    // per-channel sticky flags; a set in the clearing cycle survives
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_flag
            assign flag_set[g] = avg_done && (chan_r == 4'(g)) && violation && !mask_i[g];
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    flags_r[g] <= 1'b0;
                end else if (ce_i) begin
                    if (flag_set[g]) begin
                        flags_r[g] <= 1'b1;
                    end else if (flag_clr[g]) begin
                        flags_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // primary flags: temperatures and analog inputs 3..8
    assign status1 = {flags_r[10:5], flags_r[CH_EXT_TEMP], flags_r[CH_INT_TEMP]};
    // secondary flags: supply and the two shared inputs
    assign status2 = {5'h00, flags_r[CH_SUPPLY], flags_r[CH_AIN2], flags_r[CH_AIN1]};

    // reading a status register clears what it showed
    always_comb begin
        flag_clr = '0;
        if (reg_rd_i && reg_addr_i == ADDR_FLAGS_PRIMARY) begin
            flag_clr[CH_INT_TEMP] = 1'b1;
            flag_clr[CH_EXT_TEMP] = 1'b1;
            flag_clr[10:5]        = 6'h3F;
        end
        if (reg_rd_i && reg_addr_i == ADDR_FLAGS_SECONDARY) begin
            flag_clr[CH_SUPPLY] = 1'b1;
            flag_clr[CH_AIN1]   = 1'b1;
            flag_clr[CH_AIN2]   = 1'b1;
        end
    end

    // averaging on after reset; the only writable register here
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl2_r <= CTRL2_RESET;
        end else if (ce_i && reg_wr_i && reg_addr_i == ADDR_CHANNEL_MODE) begin
            ctrl2_r <= reg_wdata_i;
        end
    end

    // read data; unmapped addresses answer zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_rd_i) begin
            reg_rdata_o <= 8'h00;
            case (reg_addr_i)
                ADDR_FLAGS_PRIMARY:   reg_rdata_o <= status1;
                ADDR_FLAGS_SECONDARY: reg_rdata_o <= status2;
                // supply split low two bits and upper eight
                ADDR_SUPPLY_LOW:      reg_rdata_o <= {6'h00, result_mem[CH_SUPPLY][1:0]};
                ADDR_SUPPLY_HIGH:     reg_rdata_o <= result_mem[CH_SUPPLY][9:2];
                ADDR_CHANNEL_MODE:    reg_rdata_o <= ctrl2_r;
                default: begin
                    // every result as an upper byte and a low-bits byte
                    for (int i = 0; i < NCH; i++) begin
                        if (reg_addr_i == ADDR_RESULT_BASE + 8'(2 * i)) begin
                            reg_rdata_o <= result_mem[i][9:2];
                        end
                        if (reg_addr_i == ADDR_RESULT_BASE + 8'(2 * i + 1)) begin
                            reg_rdata_o <= {6'h00, result_mem[i][1:0]};
                        end
                    end
                end
            endcase
        end
    end

    // interrupt pin follows any flag at the chosen polarity
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            int_o <= 1'b0;
        end else if (ce_i) begin
            int_o <= (|flags_r) ? int_active_high_i : !int_active_high_i;
        end
    end

    // front end controls; converter held in reset during serial traffic
    assign conv_active_o  = (state_r == ST_CONVERT) && !serial_active_i;
    assign conv_channel_o = chan_r;
    assign adc_reset_o    = serial_active_i;
    // supply always uses the internal reference
    assign conv_use_int_ref_o = (chan_r == CH_SUPPLY);

endmodule : measurement_sequencer_limit_monitor

`default_nettype wire

// File: core/monseq_pkg.sv
// Constants shared by the measurement sequencer and its helpers.
// Assumes a single 20 MHz clock domain; times are kept in ns.
`default_nettype none

package monseq_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 50;

    // register offsets of the host-visible map
    localparam logic [7:0] ADDR_FLAGS_PRIMARY   = 8'h00;
    localparam logic [7:0] ADDR_FLAGS_SECONDARY = 8'h01;
    localparam logic [7:0] ADDR_SUPPLY_LOW      = 8'h03;
    localparam logic [7:0] ADDR_SUPPLY_HIGH     = 8'h06;
    localparam logic [7:0] ADDR_CHANNEL_MODE    = 8'h19;
    localparam logic [7:0] ADDR_RESULT_BASE     = 8'h20;  // two bytes per channel

    // channel mode control fields and value after reset
    localparam int         CTRL2_SEL_LSB    = 0;
    localparam int         CTRL2_SINGLE_BIT = 4;
    localparam int         CTRL2_AVG_OFF    = 5;
    localparam logic [7:0] CTRL2_RESET      = 8'h00;

    // channel numbering: supply, internal, external, then analog inputs 1..8
    localparam int         NUM_CHANNELS = 11;
    localparam logic [3:0] CH_SUPPLY    = 4'h0;
    localparam logic [3:0] CH_INT_TEMP  = 4'h1;
    localparam logic [3:0] CH_EXT_TEMP  = 4'h2;
    localparam logic [3:0] CH_AIN1      = 4'h3;
    localparam logic [3:0] CH_AIN2      = 4'h4;
    localparam logic [3:0] CH_AIN3      = 4'h5;
    localparam logic [3:0] CH_LAST      = 4'hA;

    // result format and averaging
    localparam int CODE_BITS   = 10;
    localparam int LIMIT_BITS  = 8;
    localparam int AVG_COUNT   = 16;
    localparam int ADC_STEPS   = 1024;  // one count is reference / ADC_STEPS

    // one slow-speed reading per channel type
    localparam int INT_TEMP_TIME_NS = 712000;
    localparam int EXT_TEMP_TIME_NS = 1510000;
    localparam int VOLT_TIME_NS     = 712000;
    localparam int INT_TEMP_CYCLES  = (INT_TEMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_TEMP_CYCLES  = (EXT_TEMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VOLT_CYCLES      = (VOLT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : monseq_pkg

`default_nettype wire

// File: core/limit_compare.sv
// Window comparator of one result against an 8-bit upper and lower limit.
// Assumes the caller selects signed mode for temperature channels.
`timescale 1ns/1ps
`default_nettype none

module limit_compare #(
    parameter int CODE_W  = 10,
    parameter int LIMIT_W = 8
) (
    // result and limits
    input  wire logic [CODE_W-1:0]  code_i,
    input  wire logic [LIMIT_W-1:0] upper_i,
    input  wire logic [LIMIT_W-1:0] lower_i,
    input  wire logic               signed_i,
    // verdict
    output logic                    violation_o
);

    logic [LIMIT_W-1:0] top_bits;
    logic               above;
    logic               below_eq;

    // only the upper bits meet the narrow limit
    assign top_bits = code_i[CODE_W-1 -: LIMIT_W];

    // temperatures are twos complement, voltages straight binary
    always_comb begin
        if (signed_i) begin
            above    = $signed(top_bits) > $signed(upper_i);
            below_eq = $signed(top_bits) <= $signed(lower_i);
        end else begin
            above    = top_bits > upper_i;
            below_eq = top_bits <= lower_i;
        end
    end

    assign violation_o = above | below_eq;

endmodule : limit_compare

`default_nettype wire

// File: core/reading_averager.sv
// Accumulates successive readings and yields their mean, or passes one through.
// Assumes clear_i is raised whenever the sequence is aborted or stopped.
`timescale 1ns/1ps
`default_nettype none

module reading_averager #(
    parameter int CODE_W = 10,
    parameter int COUNT  = 16
) (
    // clock, reset, enable
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // control
    input  wire logic              clear_i,
    input  wire logic              avg_enable_i,
    // readings in
    input  wire logic              sample_valid_i,
    input  wire logic [CODE_W-1:0] sample_i,
    // result out
    output logic                   done_o,
    output logic [CODE_W-1:0]      result_o
);

    localparam int CNT_W = $clog2(COUNT);
    localparam int ACC_W = CODE_W + CNT_W;

    logic [CNT_W-1:0] count_r;
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic             last;

    assign acc_nxt = acc_r + ACC_W'(sample_i);
    assign last    = !avg_enable_i || (count_r == CNT_W'(COUNT - 1));

    // running sum; a power-of-two count makes the mean a plain shift
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            count_r  <= '0;
            acc_r    <= '0;
            done_o   <= 1'b0;
            result_o <= '0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (clear_i) begin
                count_r <= '0;
                acc_r   <= '0;
            end else if (sample_valid_i) begin
                if (last) begin
                    count_r  <= '0;
                    acc_r    <= '0;
                    done_o   <= 1'b1;
                    result_o <= avg_enable_i ? acc_nxt[ACC_W-1:CNT_W] : sample_i;
                end else begin
                    count_r <= count_r + CNT_W'(1);
                    acc_r   <= acc_nxt;
                end
            end
        end
    end

endmodule : reading_averager

`default_nettype wire

// File: verification/monseq_checker_assertions.sv
// Port checker for the measurement sequencer.
// Assumes one clock domain; bound to every sequencer instance.
`timescale 1ns/1ps
`default_nettype none

module monseq_checker
    import monseq_pkg::*;
(
    // clock and reset
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    // register port
    input wire logic       reg_rd_i,
    input wire logic       serial_active_i,
    input wire logic [7:0] reg_rdata_o,
    // configuration
    input wire logic       monitor_enable_i,
    input wire logic       int_active_high_i,
    // front end and interrupt
    input wire logic       conv_active_o,
    input wire logic [3:0] conv_channel_o,
    input wire logic       conv_use_int_ref_o,
    input wire logic       adc_reset_o,
    input wire logic       int_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // serial traffic halts and resets the converter
    property p_halt;
        serial_active_i |-> !conv_active_o;
    endproperty
    a_halt: assert property (p_halt) else $error("converting during serial access");
    property p_adc_rst;
        adc_reset_o == serial_active_i;
    endproperty
    a_adc_rst: assert property (p_adc_rst) else $error("adc reset wrong");
    // conversion runs after two cycles enabled with the bus quiet
    property p_resume;
        (monitor_enable_i && !serial_active_i && ce_i) [*2] |-> conv_active_o;
    endproperty
    a_resume: assert property (p_resume) else $error("conversion not restarted");
    property p_off;
        !monitor_enable_i |=> !conv_active_o;
    endproperty
    a_off: assert property (p_off) else $error("converting while disabled");
    property p_ref;
        conv_active_o |-> conv_use_int_ref_o == (conv_channel_o == CH_SUPPLY);
    endproperty
    a_ref: assert property (p_ref) else $error("reference choice wrong");
    // interrupt level follows polarity with no flags after reset
    property p_int_start;
        $past(rst_i) && ce_i |=> int_o == !$past(int_active_high_i);
    endproperty
    a_int_start: assert property (p_int_start) else $error("idle interrupt level");
    property p_pol;
        $changed(int_active_high_i) && !conv_active_o && !reg_rd_i && !$past(reg_rd_i)
            && !$past(rst_i) && ce_i |=> int_o != $past(int_o);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity change ignored");
    // a channel holds steady for the eight cycles after each change
    property p_stand;
        $changed(conv_channel_o) |=> $stable(conv_channel_o) [*8];
    endproperty
    a_stand: assert property (p_stand) else $error("channel left too soon");
    property p_rd_hold;
        !reg_rd_i |=> $stable(reg_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_rd_reset;
        $past(rst_i) |-> reg_rdata_o == 8'h00;
    endproperty
    a_rd_reset: assert property (p_rd_reset) else $error("read data not cleared");

    c_abort: cover property (serial_active_i && monitor_enable_i);
    c_int: cover property (int_o == int_active_high_i);
    c_step: cover property ($changed(conv_channel_o) && conv_active_o);
endmodule : monseq_checker

bind measurement_sequencer_limit_monitor monseq_checker u_chk (
    .mclk_i            (mclk_i),
    .rst_i             (rst_i),
    .ce_i              (ce_i),
    .reg_rd_i          (reg_rd_i),
    .serial_active_i   (serial_active_i),
    .reg_rdata_o       (reg_rdata_o),
    .monitor_enable_i  (monitor_enable_i),
    .int_active_high_i (int_active_high_i),
    .conv_active_o     (conv_active_o),
    .conv_channel_o    (conv_channel_o),
    .conv_use_int_ref_o(conv_use_int_ref_o),
    .adc_reset_o       (adc_reset_o),
    .int_o             (int_o)
);

`default_nettype wire

// File: verification/host_model.sv
// Host model standing in for the serial engine on the register port.
// Assumes one access at a time; every access is framed by serial_o.
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // clock
    input  wire logic       mclk_i,
    // register port
    input  wire logic [7:0] rdata_i,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic            serial_o
);
    // quiet bus at time zero
    initial begin
        addr_o   = 8'h00;
        wdata_o  = 8'h00;
        wr_o     = 1'b0;
        rd_o     = 1'b0;
        serial_o = 1'b0;
    end

    // one framed access; released lines show inverted values, not stale ones
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge mclk_i);
        serial_o = 1'b1;
        @(negedge mclk_i);
        addr_o  = a;
        wdata_o = d;
        wr_o    = w;
        rd_o    = !w;
        @(negedge mclk_i);
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
        @(negedge mclk_i);
        q        = rdata_i;
        serial_o = 1'b0;
    endtask : xfer

    // a long transaction with no register strobe
    task automatic hold(input int n);
        @(negedge mclk_i);
        serial_o = 1'b1;
        repeat (n) @(negedge mclk_i);
        serial_o = 1'b0;
    endtask : hold
endmodule : host_model

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the measurement sequencer with limit monitor.
// Assumes short reading windows; the bench plays the analog front end.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); end end

module tb_top;
    import monseq_pkg::*;
    logic             mclk_i = 1'b0;
    logic             rst_i  = 1'b1;
    logic [7:0]       addr, wdata, rdata, q;
    logic             wr, rd, serial, conv_active, use_ref, adc_rst, int_pin;
    logic             mon_en = 1'b0;
    logic             ext_en = 1'b1;
    logic             pol    = 1'b1;
    logic [10:0]      mask   = '1;
    logic [87:0]      upper  = '1;
    logic [87:0]      lower  = '0;
    logic [9:0]       code_tab [11];
    logic [3:0]       conv_ch;
    int               miscompares = 0;
    int               n_checks    = 0;

    // 20 MHz clock
    always #25 mclk_i = ~mclk_i;

    // front end answers per channel, inverted while idle
    wire logic [9:0] adc_code = conv_active ? code_tab[conv_ch] : ~code_tab[conv_ch];

    host_model host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
                     .wr_o(wr), .rd_o(rd), .serial_o(serial));

    measurement_sequencer_limit_monitor #(.INT_CYCLES(20), .EXT_CYCLES(30),
                                          .AIN_CYCLES(10)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .serial_active_i(serial), .reg_rdata_o(rdata),
        .monitor_enable_i(mon_en), .ext_sensor_enable_i(ext_en),
        .int_active_high_i(pol), .mask_i(mask),
        .upper_limit_i(upper), .lower_limit_i(lower),
        .adc_code_i(adc_code), .conv_active_o(conv_active), .conv_channel_o(conv_ch),
        .conv_use_int_ref_o(use_ref), .adc_reset_o(adc_rst), .int_o(int_pin));

    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wrr
    task automatic rdr(input logic [7:0] a);
        host.xfer(1'b0, a, 8'h00, q);
    endtask : rdr
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cyc

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // idle after reset, interrupt follows polarity
    task automatic t_reset;
        rdr(ADDR_CHANNEL_MODE);
        `CHK("mode reg", CTRL2_RESET, q)
        `CHK("idle conv", 1'b0, conv_active)
        pol = 1'b0;
        cyc(2);
        `CHK("int idle", 1'b1, int_pin)
        pol = 1'b1;
        cyc(2);
        `CHK("int idle", 1'b0, int_pin)
    endtask : t_reset

    // single supply channel, averaging off
    task automatic t_supply;
        wrr(ADDR_CHANNEL_MODE, 8'h30);
        mon_en = 1'b1;
        cyc(40);
        `CHK("channel", CH_SUPPLY, conv_ch)
        `CHK("int ref", 1'b1, use_ref)
        rdr(ADDR_SUPPLY_HIGH);
        `CHK("supply hi", 8'hB6, q)
        rdr(ADDR_SUPPLY_LOW);
        `CHK("supply lo", 2'b11, q[1:0])
    endtask : t_supply

    // window edges, masking and polarity on the supply
    task automatic t_limits;
        logic [17:0] row [4] = '{{1'b0, 8'hB5, 8'h00, 1'b1}, {1'b0, 8'hFF, 8'hB6, 1'b1},
                                 {1'b0, 8'hB6, 8'hB5, 1'b0}, {1'b1, 8'hB5, 8'h00, 1'b0}};
        for (int i = 0; i < 4; i++) begin
            {mask[0], upper[7:0], lower[7:0]} = row[i][17:1];
            pol = i[0];
            rdr(ADDR_FLAGS_SECONDARY);
            cyc(40);
            `CHK("int pin", row[i][0] ? pol : !pol, int_pin)
            rdr(ADDR_FLAGS_SECONDARY);
            `CHK("supply flag", row[i][0], q[2])
        end
    endtask : t_limits

    // signed temperature compare on the internal sensor
    task automatic t_temp;
        logic [26:0] row [2] = '{{10'h064, 8'h18, 8'h00, 1'b1},
                                 {10'h3D8, 8'h7F, 8'hF0, 1'b0}};
        mask[1] = 1'b0;
        wrr(ADDR_CHANNEL_MODE, 8'h31);
        for (int i = 0; i < 2; i++) begin
            {code_tab[1], upper[15:8], lower[15:8]} = row[i][26:1];
            rdr(ADDR_FLAGS_PRIMARY);
            cyc(40);
            rdr(ADDR_FLAGS_PRIMARY);
            `CHK("temp flag", row[i][0], q[0])
            rdr(ADDR_RESULT_BASE + 8'h02);
            `CHK("temp hi", row[i][26:19], q)
        end
        mask[1] = 1'b1;
    endtask : t_temp

    // sixteen readings before a result appears
    task automatic t_avg;
        mask[5] = 1'b0;
        upper[47:40] = 8'h7F;
        wrr(ADDR_CHANNEL_MODE, 8'h15);
        // the internal channel must finish its own sixteen readings first
        cyc(430);
        rdr(ADDR_RESULT_BASE + 8'h0A);
        `CHK("avg early", 8'h00, q)
        cyc(200);
        rdr(ADDR_RESULT_BASE + 8'h0A);
        `CHK("avg result", 8'h80, q)
        rdr(ADDR_FLAGS_PRIMARY);
        `CHK("ain flag", 1'b1, q[2])
        // unused channels stay masked
        mask[5] = 1'b1;
    endtask : t_avg

    // a transaction stops and then restarts the converter
    task automatic t_abort;
        fork
            host.hold(6);
            begin
                cyc(3);
                `CHK("halt", 1'b0, conv_active)
                `CHK("adc reset", 1'b1, adc_rst)
            end
        join
        cyc(2);
        `CHK("resume", 1'b1, conv_active)
        `CHK("same ch", CH_AIN3, conv_ch)
    endtask : t_abort

    // round robin order with the external sensor on, then off
    task automatic t_rr;
        logic [3:0] prev;
        logic [3:0] nxt;
        int         n;
        wrr(ADDR_CHANNEL_MODE, 8'h20);
        prev = conv_ch;
        for (int k = 0; k < 19; k++) begin
            // later passes drop the external sensor for the two shared inputs
            ext_en = (k < 12);
            n = 0;
            while (conv_ch === prev && n < 200) begin
                @(negedge mclk_i);
                n++;
            end
            if (n == 200) begin
                miscompares++;
                close_out();
            end
            nxt = (prev == CH_INT_TEMP && !ext_en) ? CH_AIN1 : (prev == CH_EXT_TEMP) ? CH_AIN3
                  : (prev == CH_LAST) ? CH_SUPPLY : prev + 4'h1;
            `CHK("next channel", nxt, conv_ch)
            prev = conv_ch;
        end
    endtask : t_rr

    // main sequence
    initial begin
        foreach (code_tab[i])
            code_tab[i] = 10'h100;
        code_tab[0] = 10'h2DB;
        code_tab[5] = 10'h200;
        repeat (12) @(negedge mclk_i);
        rst_i = 1'b0;
        t_reset();
        t_supply();
        t_limits();
        t_temp();
        t_avg();
        t_abort();
        t_rr();
        close_out();
    end
endmodule : tb_top

`default_nettype wire
